// >>> rtl/cis_defs.svh
// constants for the instruction semantics execution unit
// Operation
// - decrement-branch-on-false: if condition false, decrement count, branch unless it is -1
// - compares subtract source from destination, store nothing; N Z V C set, X kept
// - or, xor, complement write result; N Z from result, V C cleared, X kept
// - logical shifts by count update N Z C, and X only for a nonzero count; always clear V
// - plain rotates keep X, extend rotates update X; both set N Z C, clear V
// - data move copies source; N Z from value, V C cleared, X kept
// - move to flag byte loads all five flags from the source
// - move to status word loads the whole word, flags included
// - move from status word copies it out, flags untouched
// - user stack pointer moves to or from an address register, no flags
// - quick move loads immediate; N Z set, V C cleared, X kept
// - decimal negate and subtract in packed BCD with X; X Z C updated
// - negate with extend stores zero minus operand minus X, arithmetic flags
// - set-on-condition writes 0xFF if condition holds else 0x00, no flags
// - load-and-halt loads status word from immediate, then stops execution
// - halfword swap exchanges register halves; N Z set, V C cleared
// - test-and-set: N Z from byte, C cleared, V kept, then bit 7 set
// - trap pushes PC then status word, loads PC from vector, no flags
// - operand test sets N Z, clears V C, keeps X, stores nothing
// - frame allocation pushes address reg, copies SP to it, adds displacement
// - return-restore pops flags then PC, loading all five flags
// - subroutine jump pushes return PC predecremented then loads destination
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
// ==========================================================================
// status word layout
`define CIS_SR_C      0
`define CIS_SR_V      1
`define CIS_SR_Z      2
`define CIS_SR_N      3
`define CIS_SR_X      4
`define CIS_SR_RST    16'h0000
// ==========================================================================
// register map and fields
`define CIS_CTRL_OFS  12'h000
`define CIS_STAT_OFS  12'h004
`define CIS_USP_OFS   12'h008
`define CIS_CTRL_EN   0
`define CIS_CTRL_RES  1
`define CIS_STAT_HLT  16
`define CIS_EN_RST    1'b1
// ==========================================================================
// stack arithmetic
`define CIS_LONG_B    32'h0000_0004
`define CIS_TRAP_B    32'h0000_0006
`endif

// >>> rtl/cis_pkg.sv
// types for the instruction semantics execution unit
package cis_pkg;
    typedef enum logic [4:0] {
        OP_CMP      = 5'b00000,
        OP_DBF      = 5'b00001,
        OP_OR       = 5'b00010,
        OP_EOR      = 5'b00011,
        OP_NOT      = 5'b00100,
        OP_LSL      = 5'b00101,
        OP_LSR      = 5'b00110,
        OP_ROL      = 5'b00111,
        OP_ROR      = 5'b01000,
        OP_ROTATE_LEFT_THRU_EXTEND     = 5'b01001,
        OP_ROTATE_RIGHT_THRU_EXTEND     = 5'b01010,
        OP_MOVE     = 5'b01011,
        OP_TO_CCR   = 5'b01100,
        OP_TO_SR    = 5'b01101,
        OP_FROM_SR  = 5'b01110,
        OP_USP_AN   = 5'b01111,
        OP_AN_USP   = 5'b10000,
        OP_MOVE_QUICK_IMM    = 5'b10001,
        OP_DECIMAL_NEGATE     = 5'b10010,
        OP_DECIMAL_SUBTRACT     = 5'b10011,
        OP_NEGATE_WITH_EXTEND_BIT     = 5'b10100,
        OP_SCC      = 5'b10101,
        OP_STOP     = 5'b10110,
        OP_SWAP     = 5'b10111,
        OP_TAS      = 5'b11000,
        OP_TRAP     = 5'b11001,
        OP_TST      = 5'b11010,
        OP_LINK     = 5'b11011,
        OP_RTR      = 5'b11100,
        OP_JSR      = 5'b11101
    } cis_op_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_PUSH2 = 2'b01
    } cis_state_t;
    typedef struct packed {
        logic        valid;
        cis_op_t     op;
        logic [1:0]  size;
        logic        cond_true;
        logic [5:0]  count;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] imm;
        logic [31:0] pc;
        logic [31:0] an;
        logic [31:0] sp;
        logic [31:0] vector;
    } cis_req_t;
    typedef struct packed {
        logic        done;
        logic        wr_dst;
        logic [31:0] res;
        logic        pc_ld;
        logic [31:0] pc;
        logic        sp_wr;
        logic [31:0] sp;
        logic        an_wr;
        logic [31:0] an;
        logic        mem_wr;
        logic        mem_long;
        logic [31:0] mem_addr;
        logic [31:0] mem_data;
    } cis_rsp_t;
endpackage

// >>> rtl/cis_exec.sv
// execution unit: operation semantics, flags, stack effects, apb slave
`include "cis_defs.svh"
module cis_exec (
    input  wire logic              MCLK,
    input  wire logic              RST_B,
    input  wire cis_pkg::cis_req_t REQ,
    output logic                   REQ_READY,
    output cis_pkg::cis_rsp_t      RSP,
    output logic [15:0]            SR_OUT,
    output logic                   HALTED,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR
);
    import cis_pkg::*;

    // ======================================================================
    // helpers
    function automatic logic [31:0] szm(input logic [1:0] sz);
        case (sz)
            2'b00:   szm = 32'h0000_00FF;
            2'b01:   szm = 32'h0000_FFFF;
            default: szm = 32'hFFFF_FFFF;
        endcase
    endfunction

    function automatic logic top(input logic [31:0] v,
                                 input logic [1:0]  sz);
        case (sz)
            2'b00:   top = v[7];
            2'b01:   top = v[15];
            default: top = v[31];
        endcase
    endfunction

    function automatic logic zro(input logic [31:0] v,
                                 input logic [1:0]  sz);
        zro = ((v & szm(sz)) == 32'h0000_0000);
    endfunction

    // only the sized part of a register destination changes
    function automatic logic [31:0] mrg(input logic [31:0] d,
                                        input logic [31:0] r,
                                        input logic [1:0]  sz);
        mrg = (d & ~szm(sz)) | (r & szm(sz));
    endfunction

    // packed bcd a - b - x, returns {borrow, digits}
    function automatic logic [8:0] bcd(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       x);
        logic [4:0] lo;
        logic [8:0] raw;
        logic [8:0] t;
        lo  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, x};
        raw = {1'b0, a} - {1'b0, b} - {8'h00, x};
        t   = raw;
        if (lo[4]) begin
            t = t - 9'h006;
        end
        if (raw[8]) begin
            t = t - 9'h060;
        end
        bcd = {raw[8], t[7:0]};
    endfunction

    // ======================================================================
    // state
    cis_state_t  state_r, state_nxt;
    logic [15:0] sr_r, sr_nxt;
    logic [31:0] usp_r, usp_nxt;
    logic        halted_r, en_r, ready_r;
    logic [15:0] trap_sr_r;
    logic [31:0] trap_sp_r, trap_vec_r;
    cis_rsp_t    rsp_r, rsp_nxt;

    wire logic acc = REQ.valid & ready_r;
    wire logic [1:0] sz = REQ.size;
    wire logic [31:0] d = REQ.dst;
    wire logic [31:0] s = REQ.src;
    wire logic [4:0] fl = sr_r[4:0];
    wire logic is_left = (REQ.op == OP_LSL) | (REQ.op == OP_ROL)
                       | (REQ.op == OP_ROTATE_LEFT_THRU_EXTEND);
    wire logic is_rox = (REQ.op == OP_ROTATE_LEFT_THRU_EXTEND) | (REQ.op == OP_ROTATE_RIGHT_THRU_EXTEND);
    wire logic [31:0] sp_dec = REQ.sp - `CIS_LONG_B;
    wire logic [15:0] cnt_dec = d[15:0] - 16'h0001;

    // ======================================================================
    // apb decode
    wire logic apb_fire = PSEL & PENABLE & PREADY;
    wire logic apb_wr = apb_fire & PWRITE;
    wire logic hit_ctrl = (PADDR == `CIS_CTRL_OFS);
    wire logic hit_stat = (PADDR == `CIS_STAT_OFS);
    wire logic hit_usp = (PADDR == `CIS_USP_OFS);
    wire logic hit_any = hit_ctrl | hit_stat | hit_usp;
    wire logic resume = apb_wr & hit_ctrl & PWDATA[`CIS_CTRL_RES];
    wire logic [31:0] rd_mux =
        hit_ctrl ? {31'h0000_0000, en_r} :
        hit_stat ? {15'h0000, halted_r, sr_r} :
        hit_usp  ? usp_r : 32'h0000_0000;

    // ======================================================================
    // operation semantics
    logic [31:0] r, sv;
    logic [4:0]  f;
    logic        sc, sx, ib, halt_set, go_push2;
    logic [8:0]  bq;

    always_comb begin
        rsp_nxt  = '0;
        sr_nxt   = sr_r;
        f        = fl;
        usp_nxt  = usp_r;
        halt_set = 1'b0;
        go_push2 = 1'b0;
        r        = 32'h0000_0000;
        sv       = 32'h0000_0000;
        sc       = 1'b0;
        sx       = fl[`CIS_SR_X];
        ib       = 1'b0;
        bq       = 9'h000;
        rsp_nxt.done = acc && REQ.op != OP_TRAP;
        case (REQ.op)
            OP_CMP: begin
                r = d - s;
                f[`CIS_SR_N] = top(r, sz);
                f[`CIS_SR_Z] = zro(r, sz);
                f[`CIS_SR_V] = (top(s, sz) ^ top(d, sz))
                             & (top(r, sz) ^ top(d, sz));
                f[`CIS_SR_C] = (top(s, sz) & ~top(d, sz))
                             | (top(r, sz) & ~top(d, sz))
                             | (top(s, sz) & top(r, sz));
            end
            OP_DBF: begin
                if (!REQ.cond_true) begin
                    rsp_nxt.wr_dst = 1'b1;
                    rsp_nxt.res = {d[31:16], cnt_dec};
                    rsp_nxt.pc_ld = (cnt_dec != 16'hFFFF);
                    rsp_nxt.pc = REQ.pc + REQ.imm;
                end
            end
            OP_OR, OP_EOR, OP_NOT, OP_MOVE, OP_MOVE_QUICK_IMM, OP_TST: begin
                case (REQ.op)
                    OP_OR:   r = d | s;
                    OP_EOR:  r = d ^ s;
                    OP_NOT:  r = ~d;
                    OP_MOVE: r = s;
                    OP_MOVE_QUICK_IMM: r = {{24{REQ.imm[7]}}, REQ.imm[7:0]};
                    default: r = d;
                endcase
                if (REQ.op == OP_MOVE_QUICK_IMM) begin
                    f[`CIS_SR_N] = r[31];
                    f[`CIS_SR_Z] = (r == 32'h0000_0000);
                    rsp_nxt.res = r;
                end else begin
                    f[`CIS_SR_N] = top(r, sz);
                    f[`CIS_SR_Z] = zro(r, sz);
                    rsp_nxt.res = mrg(d, r, sz);
                end
                f[`CIS_SR_V] = 1'b0;
                f[`CIS_SR_C] = 1'b0;
                rsp_nxt.wr_dst = (REQ.op != OP_TST);
            end
            OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ROTATE_LEFT_THRU_EXTEND, OP_ROTATE_RIGHT_THRU_EXTEND: begin
                // count 0 leaves carry at 0, or at X for extend rotates
                sv = d & szm(sz);
                sc = is_rox ? fl[`CIS_SR_X] : 1'b0;
                for (int i = 0; i < 64; i++) begin
                    if (i < int'(REQ.count)) begin
                        if (is_left) begin
                            sc = top(sv, sz);
                            ib = (REQ.op == OP_ROL) ? sc :
                                 (REQ.op == OP_ROTATE_LEFT_THRU_EXTEND) ? sx : 1'b0;
                            sv = ((sv << 1) | {31'h0, ib}) & szm(sz);
                        end else begin
                            ib = (REQ.op == OP_ROR) ? sv[0] :
                                 (REQ.op == OP_ROTATE_RIGHT_THRU_EXTEND) ? sx : 1'b0;
                            sc = sv[0];
                            sv = (sv >> 1)
                               | (ib ? (szm(sz) & ~(szm(sz) >> 1))
                                     : 32'h0000_0000);
                        end
                        if (is_rox) begin
                            sx = sc;
                        end
                    end
                end
                f[`CIS_SR_N] = top(sv, sz);
                f[`CIS_SR_Z] = zro(sv, sz);
                f[`CIS_SR_V] = 1'b0;
                f[`CIS_SR_C] = sc;
                if (is_rox) begin
                    f[`CIS_SR_X] = sx;
                end else if ((REQ.op == OP_LSL || REQ.op == OP_LSR)
                             && REQ.count != 6'd0) begin
                    f[`CIS_SR_X] = sc;
                end
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = mrg(d, sv, sz);
            end
            OP_TO_CCR: f = s[4:0];
            OP_TO_SR: begin
                sr_nxt = s[15:0];
                f = s[4:0];
            end
            OP_FROM_SR: begin
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = mrg(d, {16'h0000, sr_r}, 2'b01);
            end
            OP_USP_AN: begin
                rsp_nxt.an_wr = 1'b1;
                rsp_nxt.an = usp_r;
            end
            OP_AN_USP: usp_nxt = REQ.an;
            OP_DECIMAL_NEGATE, OP_DECIMAL_SUBTRACT: begin
                bq = (REQ.op == OP_DECIMAL_NEGATE)
                   ? bcd(8'h00, d[7:0], fl[`CIS_SR_X])
                   : bcd(d[7:0], s[7:0], fl[`CIS_SR_X]);
                f[`CIS_SR_X] = bq[8];
                f[`CIS_SR_C] = bq[8];
                f[`CIS_SR_Z] = fl[`CIS_SR_Z] & (bq[7:0] == 8'h00);
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = mrg(d, {24'h000000, bq[7:0]}, 2'b00);
            end
            OP_NEGATE_WITH_EXTEND_BIT: begin
                r = 32'h0000_0000 - d
                  - {31'h0, fl[`CIS_SR_X]};
                f[`CIS_SR_N] = top(r, sz);
                f[`CIS_SR_Z] = fl[`CIS_SR_Z] & zro(r, sz);
                f[`CIS_SR_V] = top(d, sz) & top(r, sz);
                f[`CIS_SR_C] = top(d, sz) | top(r, sz);
                f[`CIS_SR_X] = top(d, sz) | top(r, sz);
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = mrg(d, r, sz);
            end
            OP_SCC: begin
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = mrg(d, REQ.cond_true ? 32'hFFFF_FFFF
                                                   : 32'h0000_0000,
                                  2'b00);
            end
            OP_STOP: begin
                sr_nxt = REQ.imm[15:0];
                f = REQ.imm[4:0];
                halt_set = acc;
            end
            OP_SWAP: begin
                r = {d[15:0], d[31:16]};
                f[`CIS_SR_N] = r[31];
                f[`CIS_SR_Z] = (r == 32'h0000_0000);
                f[`CIS_SR_V] = 1'b0;
                f[`CIS_SR_C] = 1'b0;
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = r;
            end
            OP_TAS: begin
                f[`CIS_SR_N] = d[7];
                f[`CIS_SR_Z] = (d[7:0] == 8'h00);
                f[`CIS_SR_C] = 1'b0;
                rsp_nxt.wr_dst = 1'b1;
                rsp_nxt.res = {d[31:8], 1'b1, d[6:0]};
            end
            OP_TRAP: begin
                go_push2 = acc;
                rsp_nxt.mem_wr = 1'b1;
                rsp_nxt.mem_long = 1'b1;
                rsp_nxt.mem_addr = sp_dec;
                rsp_nxt.mem_data = REQ.pc;
            end
            OP_LINK: begin
                rsp_nxt.mem_wr = 1'b1;
                rsp_nxt.mem_long = 1'b1;
                rsp_nxt.mem_addr = sp_dec;
                rsp_nxt.mem_data = REQ.an;
                rsp_nxt.an_wr = 1'b1;
                rsp_nxt.an = sp_dec;
                rsp_nxt.sp_wr = 1'b1;
                rsp_nxt.sp = sp_dec + REQ.imm;
            end
            OP_RTR: begin
                f = s[4:0];
                rsp_nxt.pc_ld = 1'b1;
                rsp_nxt.pc = d;
                rsp_nxt.sp_wr = 1'b1;
                rsp_nxt.sp = REQ.sp + `CIS_TRAP_B;
            end
            OP_JSR: begin
                rsp_nxt.mem_wr = 1'b1;
                rsp_nxt.mem_long = 1'b1;
                rsp_nxt.mem_addr = sp_dec;
                rsp_nxt.mem_data = REQ.pc;
                rsp_nxt.sp_wr = 1'b1;
                rsp_nxt.sp = sp_dec;
                rsp_nxt.pc_ld = 1'b1;
                rsp_nxt.pc = d;
            end
            default: ;
        endcase
        if (!acc) begin
            rsp_nxt = '0;
            sr_nxt = sr_r;
            f = fl;
            usp_nxt = usp_r;
        end
        sr_nxt[4:0] = f;
        // second trap beat: status word below the pushed pc
        if (state_r == ST_PUSH2) begin
            rsp_nxt = '0;
            rsp_nxt.done = 1'b1;
            rsp_nxt.mem_wr = 1'b1;
            rsp_nxt.mem_addr = trap_sp_r - `CIS_TRAP_B;
            rsp_nxt.mem_data = {16'h0000, trap_sr_r};
            rsp_nxt.sp_wr = 1'b1;
            rsp_nxt.sp = trap_sp_r - `CIS_TRAP_B;
            rsp_nxt.pc_ld = 1'b1;
            rsp_nxt.pc = trap_vec_r;
        end
    end

    // halt is set only while idle; a resume in the same cycle does not clear it
    wire logic halt_nxt = halt_set | (halted_r & ~resume);
    wire logic en_nxt = (apb_wr & hit_ctrl) ? PWDATA[`CIS_CTRL_EN] : en_r;
    assign state_nxt = go_push2 ? ST_PUSH2 : ST_IDLE;

    // ======================================================================
    // registers
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r  <= ST_IDLE;
            sr_r     <= `CIS_SR_RST;
            usp_r    <= 32'h0000_0000;
            halted_r <= 1'b0;
            en_r     <= `CIS_EN_RST;
            ready_r  <= 1'b0;
            rsp_r    <= '0;
        end else begin
            state_r  <= state_nxt;
            sr_r     <= sr_nxt;
            usp_r    <= usp_nxt;
            halted_r <= halt_nxt;
            en_r     <= en_nxt;
            ready_r  <= (state_nxt == ST_IDLE) & en_nxt & ~halt_nxt;
            rsp_r    <= rsp_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            trap_sr_r  <= 16'h0000;
            trap_sp_r  <= 32'h0000_0000;
            trap_vec_r <= 32'h0000_0000;
        end else if (go_push2) begin
            trap_sr_r  <= sr_r;
            trap_sp_r  <= REQ.sp;
            trap_vec_r <= REQ.vector;
        end
    end

    logic        pready_r, pslverr_r;
    logic [31:0] prdata_r;
    wire logic pready_nxt = PSEL & PENABLE & ~pready_r;

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= pready_nxt;
            pslverr_r <= pready_nxt & ~hit_any;
            prdata_r  <= (pready_nxt & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    assign REQ_READY = ready_r;
    assign RSP       = rsp_r;
    assign SR_OUT    = sr_r;
    assign HALTED    = halted_r;
    assign PREADY    = pready_r;
    assign PSLVERR   = pslverr_r;
    assign PRDATA    = prdata_r;

    // ======================================================================
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    dbf_count_a: assert property (
        acc && REQ.op == OP_DBF && !REQ.cond_true |=> RSP.wr_dst
        && RSP.res[15:0] == $past(REQ.dst[15:0]) - 16'h0001
        && RSP.pc_ld == (RSP.res[15:0] != 16'hFFFF)
        && SR_OUT == $past(SR_OUT))
        else $error("decrement branch wrong");

    cmp_nostore_a: assert property (
        acc && REQ.op == OP_CMP |=> !RSP.wr_dst
        && SR_OUT[`CIS_SR_X] == $past(SR_OUT[`CIS_SR_X]))
        else $error("compare stored or changed X");

    logic_vc_a: assert property (
        acc && (REQ.op == OP_OR || REQ.op == OP_EOR
                || REQ.op == OP_NOT)
        |=> SR_OUT[1:0] == 2'b00 && RSP.wr_dst
        && $stable(SR_OUT[`CIS_SR_X]))
        else $error("logic op flags wrong");

    rot_x_a: assert property (
        acc && (REQ.op == OP_ROL || REQ.op == OP_ROR)
        |=> !SR_OUT[`CIS_SR_V]
        && SR_OUT[`CIS_SR_X] == $past(SR_OUT[`CIS_SR_X]))
        else $error("plain rotate touched X or V");

    scc_byte_a: assert property (
        acc && REQ.op == OP_SCC |=> RSP.res[7:0]
        == ($past(REQ.cond_true) ? 8'hFF : 8'h00)
        && SR_OUT == $past(SR_OUT))
        else $error("set on condition wrong");

    stop_halt_a: assert property (
        acc && REQ.op == OP_STOP |=> HALTED
        && SR_OUT == $past(REQ.imm[15:0]) ##1 !REQ_READY)
        else $error("stop did not halt");

    trap_push_a: assert property (
        acc && REQ.op == OP_TRAP |=> RSP.mem_wr && !RSP.done
        && RSP.mem_data == $past(REQ.pc) ##1 RSP.mem_wr && RSP.done
        && RSP.pc == $past(REQ.vector, 2) && $stable(SR_OUT))
        else $error("trap sequence wrong");

    tas_bit_a: assert property (
        acc && REQ.op == OP_TAS |=> RSP.res[7]
        && !SR_OUT[`CIS_SR_C]
        && SR_OUT[`CIS_SR_V] == $past(SR_OUT[`CIS_SR_V]))
        else $error("test and set wrong");

    link_frame_a: assert property (
        acc && REQ.op == OP_LINK |=> RSP.an == RSP.mem_addr
        && RSP.sp == RSP.an + $past(REQ.imm)
        && RSP.mem_data == $past(REQ.an))
        else $error("frame allocation wrong");

endmodule // cis_exec

// >>> verification/cis_decode_model.sv
// decode-side model: presents one request and holds it until taken
module cis_decode_model (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire cis_pkg::cis_req_t next_req,
    input  wire logic              issue,
    input  wire logic              ready,
    output cis_pkg::cis_req_t      req
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            req <= '0;
        else if (issue)
            req <= next_req;
        else if (req.valid && ready)
            req <= ~req;  // released: inverted so stale fields never match
    end
endmodule // cis_decode_model

// >>> verification/cis_exec_tb.sv
// self-checking bench for the instruction execution unit
module cis_exec_tb;
    import cis_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_b = 1'b0, issue = 1'b0, rdy, hlt;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr;
    logic [11:0] pa = 12'h000;
    logic [31:0] pw = 32'h0000_0000, prd;
    logic [15:0] sr;
    cis_req_t    req, nr = '{valid: 1'b1, op: OP_CMP, pc: 32'h0000_2000,
        size: 2'b10, sp: 32'h0000_1000, vector: 32'h0000_3000, default: '0};
    cis_rsp_t    rsp;
    int          n_mismatch, samples_checked;
    cis_exec cis_exec_inst (.MCLK(mclk), .RST_B(rst_b), .REQ(req),
        .REQ_READY(rdy), .RSP(rsp), .SR_OUT(sr), .HALTED(hlt), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr));
    cis_decode_model cis_decode_model_inst (.clk(mclk), .rst_b(rst_b),
        .next_req(nr), .issue(issue), .ready(rdy), .req(req));
    initial forever #20 mclk = ~mclk;
    task automatic c(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        n_mismatch += int'(got !== exp);
        if (got !== exp) $display("wrong value %0t: %h, %h", $time, got, exp);
    endtask
    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wt(input bit apb);  // bounded: a dead unit cannot hang
        for (int i = 0; i < 9; i++) begin
            // outputs are looked at mid-cycle, where they have settled
            @(negedge mclk);
            if ((apb ? prdy : rsp.done | rsp.mem_wr) === 1'b1) return;
        end
        n_mismatch++;
        stop_test();
    endtask
    task automatic run(input cis_op_t op, input logic [31:0] v);
        @(posedge mclk);
        nr.op <= op;
        nr.src <= v;
        issue <= 1'b1;
        @(posedge mclk);
        issue <= 1'b0;
        wt(1'b0);
    endtask
    task automatic ap(logic w, logic [11:0] a, logic [31:0] v, logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pw <= v;
        @(posedge mclk);
        pen <= 1'b1;
        wt(1'b1);
        c(64'({perr, prd & {32{!w}}}), 64'({e, v & {32{!w}}}));
        @(posedge mclk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_exec();
        run(OP_TO_CCR, 32'h0000_001F);
        run(OP_MOVE, 32'h8000_0000);
        c({rsp.res, 32'(sr)}, 64'h8000_0000_0000_0018);
        run(OP_TRAP, 32'h0000_0000);
        c({rsp.mem_addr, rsp.mem_data}, 64'h0000_0FFC_0000_2000);
        @(negedge mclk);
        c({rsp.pc, rsp.mem_data}, 64'h0000_3000_0000_0018);
    endtask
    task automatic t_ops();
        @(posedge mclk);
        nr.dst <= 32'h0001_0005;
        run(OP_DBF, 32'h0000_0000);
        c({rsp.res, 31'h0, rsp.pc_ld}, 64'h0001_0004_0000_0001);
        @(posedge mclk);
        nr.dst <= 32'h0000_0000;
        run(OP_DBF, 32'h0000_0000);
        c({rsp.res, 31'h0, rsp.pc_ld}, 64'h0000_FFFF_0000_0000);
        @(posedge mclk);
        nr.dst <= 32'h8000_0001;
        nr.count <= 6'd1;
        run(OP_LSL, 32'h0000_0000);
        c({rsp.res, 32'(sr)}, 64'h0000_0002_0000_0011);
        @(posedge mclk);
        nr.dst <= 32'h4000_0000;
        run(OP_ROL, 32'h0000_0000);
        c({rsp.res, 32'(sr)}, 64'h8000_0000_0000_0018);
        @(posedge mclk);
        nr.dst <= 32'h1234_5600;
        nr.cond_true <= 1'b1;
        run(OP_SCC, 32'h0000_0000);
        c({rsp.res, 32'(sr)}, 64'h1234_56FF_0000_0018);
        @(posedge mclk);
        nr.imm <= 32'h0000_0004;
        run(OP_STOP, 32'h0000_0000);
        c(64'({hlt, sr}), 64'h0000_0000_0001_0004);
    endtask
    task automatic t_apb();
        // resume bit set as well: the unit is halted here
        ap(1'b1, 12'h000, 32'h0000_0003, 1'b0);
        ap(1'b0, 12'h004, 32'h0000_0004, 1'b0);
        ap(1'b1, 12'h0F0, 32'h0000_0000, 1'b1);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        t_exec();
        t_ops();
        t_apb();
        stop_test();
    end
endmodule // cis_exec_tb
